/* File: dv/spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
    // serial lines
    output logic sclk,
    output logic ssN,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        ssN = 1'b1;
        mosi = 1'b1;
    end
    // mosi moves mid low phase so the slave's late edge detect never sees it change
    task automatic xfer(input int half, input logic [7:0] dout, output logic [7:0] din);
        ssN = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #(half / 2) mosi = dout[i];
            #(half / 2) sclk = 1'b1;
            #(half) sclk = 1'b0;
            din[i] = miso;
        end
        #(half) ssN = 1'b1;
        mosi = ~mosi;
        #(half);
    endtask
endmodule

/* File: dv/spi_slave_port_tb.sv */
`timescale 1ns/1ps
module spi_slave_port_tb;
    import spi_slave_pkg::*;
    logic clk, reset_n, transmitterReset_n, receiverReset_n, srgReset_n, srgSourceSel;
    logic frameGenModeSel, txClockDirectionSel, txFrameDirectionSel, rxClockDirectionSel;
    logic rxFrameDirectionSel, txClockPolarity, txFramePolarity, rxClockPolarity;
    logic rxFramePolarity, txGpioEnable, rxGpioEnable, txDataPinValue, breakpoint, emuFree;
    logic emuSoft, txValid, txReady, rxValid, rxReady, rxOverflowClear, rxOverflow;
    logic configError, txClockPolarityRd, txFramePolarityRd, rxClockPolarityRd;
    logic rxFramePolarityRd, rxDataPinValue, refClockPinValue, txClockPinIn, txClockPinOut;
    logic txClockPinOe, txFramePinIn, txFramePinOut, txFramePinOe, txDataPinOut, txDataPinOe;
    logic rxDataPin, rxClockPinIn, rxClockPinOut, rxClockPinOe, rxFramePinIn, rxFramePinOut;
    logic rxFramePinOe, refClockPinIn, miso;
    logic [7:0] srgDivider, got;
    logic [1:0] clockStopField, txDataDelay, rxDataDelay;
    logic [2:0] txWordLength, rxWordLength;
    logic [DATA_W-1:0] txData, rxData;
    int n_fail, total_checks;
    assign miso = txDataPinOe ? txDataPinOut : 1'bz;
    spi_master_model m (.sclk(txClockPinIn), .ssN(txFramePinIn), .mosi(rxDataPin), .miso);
    spi_slave_port uut (.clk, .reset_n, .transmitterReset_n, .receiverReset_n, .srgReset_n,
        .srgSourceSel, .srgDivider, .frameGenModeSel, .clockStopField, .txWordLength,
        .rxWordLength, .txDataDelay, .rxDataDelay, .txClockDirectionSel, .txFrameDirectionSel,
        .rxClockDirectionSel, .rxFrameDirectionSel, .txClockPolarity, .txFramePolarity,
        .rxClockPolarity, .rxFramePolarity, .txGpioEnable, .rxGpioEnable, .txDataPinValue,
        .breakpoint, .emuFree, .emuSoft, .txData, .txValid, .txReady, .rxData, .rxValid,
        .rxReady, .rxOverflowClear, .rxOverflow, .configError, .txClockPolarityRd,
        .txFramePolarityRd, .rxClockPolarityRd, .rxFramePolarityRd, .rxDataPinValue,
        .refClockPinValue, .txClockPinIn, .txClockPinOut, .txClockPinOe, .txFramePinIn,
        .txFramePinOut, .txFramePinOe, .txDataPinOut, .txDataPinOe, .rxDataPin, .rxClockPinIn,
        .rxClockPinOut, .rxClockPinOe, .rxFramePinIn, .rxFramePinOut, .rxFramePinOe,
        .refClockPinIn);
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic hang;
        n_fail++;
        $display("[FAIL] wait expected done seen timeout");
        conclude();
    endtask
    // pin moves land a nanosecond after the clock edge, never on it
    task automatic sx(input int half, input logic [7:0] dout);
        @(posedge clk);
        #1 m.xfer(half, dout, got);
    endtask
    // txValid stays up between pushes; the caller lowers it once
    task automatic push(input logic [DATA_W-1:0] w);
        int n;
        n = 0;
        txData <= w;
        txValid <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (txReady !== 1'b1 && n < 50);
        if (n >= 50)
            hang();
    endtask
    task automatic recv(input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rxValid !== 1'b1 && n < 100);
        if (n >= 100)
            hang();
        check("rxData", exp, rxData);
        rxReady <= 1'b1;
        @(posedge clk);
        rxReady <= 1'b0;
    endtask
    task automatic fill_drain;
        for (int i = 0; i < FIFO_DEPTH; i++)
            push({4{i[7:0]}});
        txData <= 32'hFFFFFFFF;
        tick(2);
        check("txReady full", 1'h0, txReady);
        txValid <= 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            sx(i[0] ? 80 : 120, ~i[7:0]);
            check("miso byte", {24'h0, i[7:0]}, {24'h0, got});
            recv({24'h0, ~i[7:0]});
        end
        check("txReady drained", 1'h1, txReady);
    endtask
    task automatic emulation;
        @(posedge clk);
        breakpoint <= 1'b1;
        emuFree <= 1'b1;
        sx(80, 8'h5A);
        sx(80, 8'hC3);
        tick(10);
        check("overflow", 1'h1, rxOverflow);
        check("rxData newest", 32'hC3, rxData);
        rxOverflowClear <= 1'b1;
        rxReady <= 1'b1;
        @(posedge clk);
        {rxOverflowClear, rxReady, emuFree, emuSoft, breakpoint} <= 5'h2;
        tick(3);
        check("overflow clear", 1'h0, rxOverflow);
        push(32'hE7);
        txValid <= 1'b0;
        fork
            sx(80, 8'h96);
            begin
                tick(60);
                breakpoint <= 1'b1;
            end
        join
        check("soft word", 32'hE7, {24'h0, got});
        recv(32'h96);
        push(32'hA5);
        {breakpoint, emuSoft, txValid} <= 3'h0;
        fork
            sx(80, 8'h69);
            begin
                tick(60);
                breakpoint <= 1'b1;
            end
        join
        tick(20);
        check("aborted word", 1'h0, rxValid);
        breakpoint <= 1'b0;
    endtask
    task automatic config_bad;
        fork
            sx(80, 8'h33);
            begin
                tick(60);
                txDataDelay <= 2'h1;
            end
        join
        tick(3);
        check("cfg delay", 1'h1, configError);
        check("cfg abort", 1'h0, rxValid);
        txDataDelay <= 2'h0;
        rxWordLength <= 3'h1;
        tick(3);
        check("cfg length", 1'h1, configError);
        rxWordLength <= 3'h0;
        tick(3);
        check("cfg ok", 1'h0, configError);
    endtask
    task automatic gpio;
        @(posedge clk);
        {transmitterReset_n, receiverReset_n} <= 2'h0;
        {txGpioEnable, rxGpioEnable, txDataPinValue, refClockPinIn} <= 4'hF;
        {txClockDirectionSel, txClockPolarity, txFramePolarity} <= 3'h6;
        {rxClockDirectionSel, rxClockPolarity, rxFramePolarity} <= 3'h7;
        tick(3);
        check("data pin", 2'h3, {txDataPinOe, txDataPinOut});
        check("clock pin", 3'h7, {txClockPinOe, txClockPinOut, txClockPolarityRd});
        check("frame pin", 3'h1, {txFramePinOe, txFramePinOut, txFramePolarityRd});
        check("rx clock", 3'h7, {rxClockPinOe, rxClockPinOut, rxClockPolarityRd});
        check("rx frame", 3'h2, {rxFramePinOe, rxFramePinOut, rxFramePolarityRd});
        check("rx data", m.mosi, rxDataPinValue);
        check("ref clock", 1'h1, refClockPinValue);
        rxGpioEnable <= 1'b0;
        tick(3);
        check("ref clock off", 1'h0, refClockPinValue);
        check("rx data off", 1'h0, rxDataPinValue);
    endtask
    initial
    begin
        #200000;
        hang();
    end
    initial
    begin
        {reset_n, transmitterReset_n, receiverReset_n, srgReset_n} = 4'h0;
        {txValid, rxReady, rxOverflowClear, breakpoint, emuFree, emuSoft} = 6'h0;
        {txClockDirectionSel, txFrameDirectionSel, rxClockDirectionSel} = 3'h0;
        {rxFrameDirectionSel, txGpioEnable, rxGpioEnable, txDataPinValue} = 4'h0;
        {txClockPolarity, rxClockPolarity, rxFramePolarity} = 3'h0;
        {rxClockPinIn, rxFramePinIn, refClockPinIn} = 3'h0;
        {srgSourceSel, txFramePolarity, frameGenModeSel} = 3'h6;
        srgDivider = SRG_DIV_SLAVE;
        clockStopField = 2'h2;
        {txWordLength, rxWordLength, txDataDelay, rxDataDelay} = 10'h0;
        txData = 32'h0;
        n_fail = 0;
        total_checks = 0;
        tick(2);
        reset_n <= 1'b1;
        tick(2);
        check("reset ready", 2'h2, {txReady, rxValid});
        srgReset_n <= 1'b1;
        tick(4);
        {transmitterReset_n, receiverReset_n} <= 2'h3;
        tick(4);
        fill_drain();
        emulation();
        config_bad();
        gpio();
        conclude();
    end
endmodule

/* File: rtl/spi_slave_port.sv */
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
        logic full;
        logic empty;
    } fifo_state_t;

    fifo_state_t st_ff;
    fifo_state_t nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = inValid && !st_ff.full;
    assign pop = outReady && !st_ff.empty;
    assign inReady = !st_ff.full;
    assign outValid = !st_ff.empty;
    assign outData = mem[st_ff.rdPtr];

    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.wrPtr = AW'(st_ff.wrPtr + 1'b1);
        end
        if (pop)
        begin
            nxt_st.rdPtr = AW'(st_ff.rdPtr + 1'b1);
        end
        nxt_st.count = (AW+1)'(st_ff.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        nxt_st.full = (nxt_st.count == (AW+1)'(DEPTH));
        nxt_st.empty = (nxt_st.count == '0);
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.empty <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // memory has no reset: contents are only read behind a valid count
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[st_ff.wrPtr] <= inData;
        end
    end
endmodule

module spi_slave_port
    import spi_slave_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // section resets and sample-rate generator
    input wire logic transmitterReset_n,
    input wire logic receiverReset_n,
    input wire logic srgReset_n,
    input wire logic srgSourceSel,
    input wire logic [7:0] srgDivider,
    input wire logic frameGenModeSel,
    // serial format
    input wire logic [1:0] clockStopField,
    input wire logic [2:0] txWordLength,
    input wire logic [2:0] rxWordLength,
    input wire logic [1:0] txDataDelay,
    input wire logic [1:0] rxDataDelay,
    // pin control
    input wire logic txClockDirectionSel,
    input wire logic txFrameDirectionSel,
    input wire logic rxClockDirectionSel,
    input wire logic rxFrameDirectionSel,
    input wire logic txClockPolarity,
    input wire logic txFramePolarity,
    input wire logic rxClockPolarity,
    input wire logic rxFramePolarity,
    input wire logic txGpioEnable,
    input wire logic rxGpioEnable,
    input wire logic txDataPinValue,
    // emulation
    input wire logic breakpoint,
    input wire logic emuFree,
    input wire logic emuSoft,
    // transmit words in
    input wire logic [DATA_W-1:0] txData,
    input wire logic txValid,
    output logic txReady,
    // receive words out
    output logic [DATA_W-1:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    input wire logic rxOverflowClear,
    // status
    output logic rxOverflow,
    output logic configError,
    output logic txClockPolarityRd,
    output logic txFramePolarityRd,
    output logic rxClockPolarityRd,
    output logic rxFramePolarityRd,
    output logic rxDataPinValue,
    output logic refClockPinValue,
    // pins
    input wire logic txClockPinIn,
    output logic txClockPinOut,
    output logic txClockPinOe,
    input wire logic txFramePinIn,
    output logic txFramePinOut,
    output logic txFramePinOe,
    output logic txDataPinOut,
    output logic txDataPinOe,
    input wire logic rxDataPin,
    input wire logic rxClockPinIn,
    output logic rxClockPinOut,
    output logic rxClockPinOe,
    input wire logic rxFramePinIn,
    output logic rxFramePinOut,
    output logic rxFramePinOe,
    input wire logic refClockPinIn
);
    import spi_slave_pkg::*;

    typedef struct packed {
        xfer_state_t state;
        logic [7:0] divCnt;
        logic srgTick;
        logic sclkMeta;
        logic sclkSync;
        logic sclkPrev;
        logic ssMeta;
        logic ssSync;
        logic ssPrev;
        logic sampled;
        logic txActive;
        logic [5:0] bitCnt;
        logic [DATA_W-1:0] txShift;
        logic [DATA_W-1:0] rxShift;
        logic [DATA_W-1:0] rxWord;
        logic rxValid;
        logic rxOverflow;
        logic configError;
        logic txClockOut;
        logic txClockOe;
        logic txFrameOut;
        logic txFrameOe;
        logic txDataOut;
        logic txDataOe;
        logic rxClockOut;
        logic rxClockOe;
        logic rxFrameOut;
        logic rxFrameOe;
        logic txClockPolRd;
        logic txFramePolRd;
        logic rxClockPolRd;
        logic rxFramePolRd;
        logic rxDataVal;
        logic refClockVal;
    } port_state_t;

    function automatic logic [5:0] wordBits(input logic [2:0] code);
        case (code)
            3'h0: wordBits = WL_BITS_8;
            3'h1: wordBits = WL_BITS_12;
            3'h2: wordBits = WL_BITS_16;
            3'h3: wordBits = WL_BITS_20;
            3'h4: wordBits = WL_BITS_24;
            default: wordBits = WORD_BITS_MAX;
        endcase
    endfunction

    // MSB goes out first, so a short word is left-justified in the shifter
    function automatic logic [DATA_W-1:0] alignMsb(input logic [DATA_W-1:0] d,
                                                   input logic [2:0] code);
        alignMsb = d << (WORD_BITS_MAX - wordBits(code));
    endfunction

    port_state_t st_ff;
    port_state_t nxt_st;
    logic [DATA_W-1:0] fifoData;
    logic fifoValid;
    logic fifoPop;
    logic rxWordDone;
    logic slaveOk;
    logic txGpio;
    logic rxGpio;
    logic ssAct;
    logic ssActPrev;
    logic ssStart;
    logic sclkRise;
    logic sclkFall;
    logic sampleEdge;
    logic shiftEdge;
    logic rxOnRise;
    logic immediateStop;
    logic softStop;

    word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .inData(txData),
        .inValid(txValid),
        .inReady(txReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoPop)
    );

    assign slaveOk = clockStopField[CSTP_EN_BIT]
        && txClockDirectionSel == DIR_INPUT && txFrameDirectionSel == DIR_INPUT
        && srgSourceSel == SRG_SRC_CPU && srgDivider == SRG_DIV_SLAVE
        && txDataDelay == DLY_SLAVE && rxDataDelay == DLY_SLAVE
        && frameGenModeSel == FSG_PER_PACKET
        && txWordLength == rxWordLength && txWordLength <= WL_MAX_CODE;
    assign txGpio = !transmitterReset_n && txGpioEnable;
    assign rxGpio = !receiverReset_n && rxGpioEnable;
    // receive side reuses the transmit pins' clock and enable
    assign ssAct = txFramePolarity ? !st_ff.ssSync : st_ff.ssSync;
    assign ssActPrev = txFramePolarity ? !st_ff.ssPrev : st_ff.ssPrev;
    assign ssStart = st_ff.srgTick && ssAct && !ssActPrev;
    assign sclkRise = st_ff.srgTick && st_ff.sclkSync && !st_ff.sclkPrev;
    assign sclkFall = st_ff.srgTick && !st_ff.sclkSync && st_ff.sclkPrev;
    assign rxOnRise = clockStopField[CSTP_DLY_BIT] ^ txClockPolarity;
    assign sampleEdge = rxOnRise ? sclkRise : sclkFall;
    assign shiftEdge = rxOnRise ? sclkFall : sclkRise;
    assign immediateStop = breakpoint && !emuFree && !emuSoft;
    assign softStop = breakpoint && !emuFree && emuSoft;

    always_comb
    begin
        nxt_st = st_ff;
        fifoPop = 1'b0;
        rxWordDone = 1'b0;
        // sample-rate tick; master clock must stay well below clk/4
        if (!srgReset_n)
        begin
            nxt_st.divCnt = '0;
            nxt_st.srgTick = 1'b0;
        end
        else if (st_ff.divCnt >= srgDivider)
        begin
            nxt_st.divCnt = '0;
            nxt_st.srgTick = 1'b1;
        end
        else
        begin
            nxt_st.divCnt = 8'(st_ff.divCnt + 8'h01);
            nxt_st.srgTick = 1'b0;
        end
        if (st_ff.srgTick)
        begin
            nxt_st.sclkMeta = txClockPinIn;
            nxt_st.sclkSync = st_ff.sclkMeta;
            nxt_st.sclkPrev = st_ff.sclkSync;
            nxt_st.ssMeta = txFramePinIn;
            nxt_st.ssSync = st_ff.ssMeta;
            nxt_st.ssPrev = st_ff.ssSync;
        end
        case (st_ff.state)
            ST_IDLE:
            begin
                if (ssStart && slaveOk && !immediateStop
                    && (transmitterReset_n || receiverReset_n))
                begin
                    nxt_st.state = ST_SHIFT;
                    nxt_st.bitCnt = '0;
                    nxt_st.sampled = 1'b0;
                    nxt_st.rxShift = '0;
                    // soft halt: no new word is started on the transmit side
                    if (transmitterReset_n && !softStop && fifoValid)
                    begin
                        fifoPop = 1'b1;
                        nxt_st.txShift = alignMsb(fifoData, txWordLength);
                        nxt_st.txActive = 1'b1;
                    end
                    else
                    begin
                        nxt_st.txShift = '0;
                        nxt_st.txActive = 1'b0;
                    end
                end
            end
            ST_SHIFT:
            begin
                if (immediateStop || !slaveOk || (st_ff.srgTick && !ssAct))
                begin
                    nxt_st.state = ST_DONE;
                    nxt_st.txActive = 1'b0;
                end
                else if (sampleEdge)
                begin
                    nxt_st.rxShift = {st_ff.rxShift[MSB-1:0], rxDataPin};
                    nxt_st.sampled = 1'b1;
                    nxt_st.bitCnt = 6'(st_ff.bitCnt + 6'h01);
                    if (nxt_st.bitCnt == wordBits(rxWordLength))
                    begin
                        nxt_st.state = ST_DONE;
                        nxt_st.txActive = 1'b0;
                        rxWordDone = receiverReset_n;
                    end
                end
                else if (shiftEdge && st_ff.sampled)
                begin
                    nxt_st.txShift = {st_ff.txShift[MSB-1:0], 1'b0};
                end
            end
            ST_DONE:
            begin
                // a fresh enable edge is needed before the next word
                if (st_ff.srgTick && !ssAct)
                begin
                    nxt_st.state = ST_IDLE;
                end
            end
            default:
            begin
                nxt_st.state = ST_IDLE;
            end
        endcase
        if (rxReady && st_ff.rxValid)
        begin
            nxt_st.rxValid = 1'b0;
        end
        if (rxOverflowClear)
        begin
            nxt_st.rxOverflow = 1'b0;
        end
        // set wins over the consumer's read and the software clear
        if (rxWordDone)
        begin
            nxt_st.rxWord = nxt_st.rxShift;
            nxt_st.rxValid = 1'b1;
            if (st_ff.rxValid && !rxReady)
            begin
                nxt_st.rxOverflow = 1'b1;
            end
        end
        nxt_st.configError = clockStopField[CSTP_EN_BIT] && !slaveOk;
        nxt_st.txClockOe = txGpio && txClockDirectionSel;
        nxt_st.txClockOut = txClockPolarity;
        nxt_st.txFrameOe = txGpio && txFrameDirectionSel;
        nxt_st.txFrameOut = txFramePolarity;
        nxt_st.rxClockOe = rxGpio && rxClockDirectionSel;
        nxt_st.rxClockOut = rxClockPolarity;
        nxt_st.rxFrameOe = rxGpio && rxFrameDirectionSel;
        nxt_st.rxFrameOut = rxFramePolarity;
        nxt_st.txClockPolRd = (txGpio && !txClockDirectionSel) ? txClockPinIn
                                                                : txClockPolarity;
        nxt_st.txFramePolRd = (txGpio && !txFrameDirectionSel) ? txFramePinIn
                                                                : txFramePolarity;
        nxt_st.rxClockPolRd = (rxGpio && !rxClockDirectionSel) ? rxClockPinIn
                                                                : rxClockPolarity;
        nxt_st.rxFramePolRd = (rxGpio && !rxFrameDirectionSel) ? rxFramePinIn
                                                                : rxFramePolarity;
        nxt_st.rxDataVal = rxGpio && rxDataPin;
        nxt_st.refClockVal = txGpio && rxGpio && refClockPinIn;
        // data pin floats between packets so several slaves may share it
        nxt_st.txDataOe = txGpio || nxt_st.txActive;
        nxt_st.txDataOut = txGpio ? txDataPinValue : nxt_st.txShift[MSB];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff <= '0;
            st_ff.state <= ST_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rxData = st_ff.rxWord;
    assign rxValid = st_ff.rxValid;
    assign rxOverflow = st_ff.rxOverflow;
    assign configError = st_ff.configError;
    assign txClockPolarityRd = st_ff.txClockPolRd;
    assign txFramePolarityRd = st_ff.txFramePolRd;
    assign rxClockPolarityRd = st_ff.rxClockPolRd;
    assign rxFramePolarityRd = st_ff.rxFramePolRd;
    assign rxDataPinValue = st_ff.rxDataVal;
    assign refClockPinValue = st_ff.refClockVal;
    assign txClockPinOut = st_ff.txClockOut;
    assign txClockPinOe = st_ff.txClockOe;
    assign txFramePinOut = st_ff.txFrameOut;
    assign txFramePinOe = st_ff.txFrameOe;
    assign txDataPinOut = st_ff.txDataOut;
    assign txDataPinOe = st_ff.txDataOe;
    assign rxClockPinOut = st_ff.rxClockOut;
    assign rxClockPinOe = st_ff.rxClockOe;
    assign rxFramePinOut = st_ff.rxFrameOut;
    assign rxFramePinOe = st_ff.rxFrameOe;

    property p_txClockInput;
        @(posedge clk) disable iff (!reset_n)
        txClockDirectionSel == DIR_INPUT |=> !txClockPinOe;
    endproperty
    a_txClockInput: assert property (p_txClockInput)
        else $error("transmit clock pin driven while selected as input");

    property p_srgSpacing;
        @(posedge clk) disable iff (!reset_n)
        (st_ff.srgTick && srgReset_n && srgDivider == SRG_DIV_SLAVE)
            ##1 (srgReset_n && srgDivider == SRG_DIV_SLAVE) |-> !st_ff.srgTick ##1 st_ff.srgTick;
    endproperty
    a_srgSpacing: assert property (p_srgSpacing)
        else $error("sample tick not every second clock at divider one");

    property p_badConfigIdle;
        @(posedge clk) disable iff (!reset_n)
        (!slaveOk && st_ff.state == ST_SHIFT) |=> st_ff.state == ST_DONE;
    endproperty
    a_badConfigIdle: assert property (p_badConfigIdle)
        else $error("transfer kept running under invalid slave setup");

    property p_freshEdge;
        @(posedge clk) disable iff (!reset_n)
        (st_ff.state == ST_DONE && ssAct) |=> st_ff.state == ST_DONE;
    endproperty
    a_freshEdge: assert property (p_freshEdge)
        else $error("new packet started without enable release");

    property p_immediateStop;
        @(posedge clk) disable iff (!reset_n)
        (immediateStop && st_ff.state == ST_SHIFT) |=> (st_ff.state == ST_DONE && !txDataPinOe);
    endproperty
    a_immediateStop: assert property (p_immediateStop)
        else $error("immediate stop did not abort the packet");

    property p_overflow;
        @(posedge clk) disable iff (!reset_n)
        (rxWordDone && st_ff.rxValid && !rxReady) |=> (rxOverflow && rxValid);
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("unread word did not raise overflow");

    property p_gpioClockOut;
        @(posedge clk) disable iff (!reset_n)
        (txGpio && txClockDirectionSel) |=> (txClockPinOe && txClockPinOut == $past(txClockPolarity));
    endproperty
    a_gpioClockOut: assert property (p_gpioClockOut)
        else $error("GPIO clock pin not driving its polarity bit");

    property p_gpioFrameIn;
        @(posedge clk) disable iff (!reset_n)
        (txGpio && !txFrameDirectionSel) |=> (!txFramePinOe && txFramePolarityRd == $past(txFramePinIn));
    endproperty
    a_gpioFrameIn: assert property (p_gpioFrameIn)
        else $error("GPIO frame input not reflected");

    property p_gpioData;
        @(posedge clk) disable iff (!reset_n)
        txGpio |=> (txDataPinOe && txDataPinOut == $past(txDataPinValue));
    endproperty
    a_gpioData: assert property (p_gpioData)
        else $error("GPIO data pin not driving status bit");

    property p_gpioRxData;
        @(posedge clk) disable iff (!reset_n)
        rxGpio |=> rxDataPinValue == $past(rxDataPin);
    endproperty
    a_gpioRxData: assert property (p_gpioRxData)
        else $error("receive data level not readable");

    property p_refClock;
        @(posedge clk) disable iff (!reset_n)
        !(txGpio && rxGpio) |=> !refClockPinValue;
    endproperty
    a_refClock: assert property (p_refClock)
        else $error("reference clock readable outside double GPIO mode");
endmodule

/* File: shared/spi_slave_pkg.sv */
// Contract
// - slave: clock and frame pins are inputs
// - receive clock taken from transmit clock pin
// - receive frame taken from transmit frame pin
// - sample clock from CPU clock, divide two
// - both data delays zero in slave mode
// - frame polarity one means enable low
// - one enable activation per packet
// - free run: breakpoint ignored, shifting continues
// - both bits zero: stop and abort
// - soft: transmitter finishes word, then halts
// - receiver keeps running, overflow flagged
// - pin is GPIO: section reset, enable set
// - GPIO pin drives or reflects polarity bit
// - GPIO transmit data pin drives status bit
// - GPIO receive data pin readable
// - reference clock GPIO needs both sections
// - clock-stop field must be binary 1x
// - word lengths equal, coded 000 to 101
package spi_slave_pkg;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [7:0] SRG_DIV_SLAVE = 8'h01;
    localparam logic SRG_SRC_CPU = 1'b1;
    localparam logic DIR_INPUT = 1'b0;
    localparam logic FSG_PER_PACKET = 1'b0;
    localparam logic [1:0] DLY_SLAVE = 2'h0;
    localparam int CSTP_EN_BIT = 1;
    localparam int CSTP_DLY_BIT = 0;
    localparam logic [2:0] WL_MAX_CODE = 3'h5;
    localparam logic [5:0] WORD_BITS_MAX = 6'h20;
    localparam logic [5:0] WL_BITS_8 = 6'h08;
    localparam logic [5:0] WL_BITS_12 = 6'h0C;
    localparam logic [5:0] WL_BITS_16 = 6'h10;
    localparam logic [5:0] WL_BITS_20 = 6'h14;
    localparam logic [5:0] WL_BITS_24 = 6'h18;
    localparam int MSB = DATA_W - 1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } xfer_state_t;
endpackage
